// File: sense_cfg_pkg.sv
// Constants, register map and helper types for the switch-sense configuration bank.
//
// Overview of operation
// - pulse enable bit one drives pulsed wetting current
// - threshold codes 0..3 mean 2, 2.7, 3, 4 V
// - six 2-bit group selects, inputs 0-3 lowest
// - edge enable code zero gives no interrupt
// - code one interrupts on rising crossing
// - code two interrupts on falling crossing
// - code three interrupts on both crossings
// - low enable register covers inputs 0 to 11
// - threshold and edge enable registers reset zero
// - threshold bits 31 to 12 read zero
// - pulse enable register holds 24 bits, resets zero
`default_nettype none
package sense_cfg_pkg;

  // ************************************************************
  // Register indices; the byte address is four times the index.
  // ************************************************************
  localparam logic [7:0] IDX_PULSE_EN   = 8'h20;
  localparam logic [7:0] IDX_THR_SEL    = 8'h21;
  localparam logic [7:0] IDX_EDGE_EN_LO = 8'h22;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h30;
  localparam logic [7:0] IDX_IRQ_CLEAR  = 8'h31;
  localparam logic [7:0] IDX_IRQ_ENABLE = 8'h32;
  localparam int         ADDR_LSB       = 2;

  // ************************************************************
  // Field layout and reset values.
  // ************************************************************
  localparam int          NUM_INPUTS     = 24;
  localparam int          GROUP_SIZE     = 4;
  localparam int          NUM_GROUPS     = 6;
  localparam int          THR_W          = 2;
  localparam int          THR_FIELD_W    = 12;
  localparam int          EDGE_W         = 2;
  localparam int          EDGE_INPUTS    = 12;
  localparam int          EDGE_FIELD_W   = 24;
  localparam logic [23:0] PULSE_EN_RST   = 24'h000000;
  localparam logic [11:0] THR_SEL_RST    = 12'h000;
  localparam logic [23:0] EDGE_EN_RST    = 24'h000000;
  localparam logic [11:0] IRQ_RST        = 12'h000;

  // ************************************************************
  // Threshold voltages in millivolts and timing.
  // ************************************************************
  localparam int          MV_W           = 12;
  localparam logic [11:0] THR_MV_CODE0   = 12'd2000;
  localparam logic [11:0] THR_MV_CODE1   = 12'd2700;
  localparam logic [11:0] THR_MV_CODE2   = 12'd3000;
  localparam logic [11:0] THR_MV_CODE3   = 12'd4000;
  localparam logic [1:0]  SETTLE_CYCLES  = 2'd3;

  typedef enum logic [1:0] {
    EDGE_OFF  = 2'b00,
    EDGE_RISE = 2'b01,
    EDGE_FALL = 2'b10,
    EDGE_BOTH = 2'b11
  } edge_mode_t;

endpackage : sense_cfg_pkg
`default_nettype wire

// File: sense_cfg_regs.sv
// APB register bank for pulse enables, comparator thresholds and edge interrupts.
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
module sense_cfg_regs #(
  parameter int ADDR_W = 8
) (
  input  wire logic                    clk_i,
  input  wire logic                    nrst_i,
  input  wire logic                    psel_i,
  input  wire logic                    penable_i,
  input  wire logic                    pwrite_i,
  input  wire logic [ADDR_W-1:0]       paddr_i,
  input  wire logic [31:0]             pwdata_i,
  input  wire logic [3:0]              pstrb_i,
  output logic      [31:0]             prdata_o,
  output logic                         pready_o,
  output logic                         pslverr_o,
  input  wire logic [sense_cfg_pkg::NUM_INPUTS-1:0] comp_above_i,
  output logic      [sense_cfg_pkg::NUM_INPUTS-1:0] pulse_en_o,
  output logic      [sense_cfg_pkg::THR_FIELD_W-1:0] thr_sel_o,
  output logic      [sense_cfg_pkg::NUM_GROUPS*sense_cfg_pkg::MV_W-1:0] thr_mv_o,
  output logic                         irq_o
);
  import sense_cfg_pkg::*;

  // ************************************************************
  // Elaboration check
  // ************************************************************
  if (ADDR_W < 8 || ADDR_W > 32) begin : g_bad_addr
    $error("ADDR_W must lie between 8 and 32");
  end

  // ************************************************************
  // Helper functions
  // ************************************************************
  // Merges write data into a register value under the byte strobes.
  function automatic logic [31:0] merge_strb(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0]  strb);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction

  // Translates a 2-bit threshold code into millivolts.
  function automatic logic [11:0] code_to_mv(input logic [1:0] code);
    logic [11:0] mv;
    mv = THR_MV_CODE0;
    case (code)
      2'd1:    mv = THR_MV_CODE1;
      2'd2:    mv = THR_MV_CODE2;
      2'd3:    mv = THR_MV_CODE3;
      default: mv = THR_MV_CODE0;
    endcase
    return mv;
  endfunction

  // Turns one input's edge mode and synced crossing into a status event.
  // A function per bit keeps every bit of the event vector on a single driver.
  function automatic logic edge_event(input edge_mode_t mode,
                                      input logic       rise,
                                      input logic       fall,
                                      input logic       arm);
    logic hit;
    hit = 1'b0;
    case (mode)
      EDGE_OFF:  hit = 1'b0;
      EDGE_RISE: hit = arm & rise;
      EDGE_FALL: hit = arm & fall;
      EDGE_BOTH: hit = arm & (rise | fall);
      default:   hit = 1'b0;
    endcase
    return hit;
  endfunction

  // ************************************************************
  // Registers and decode
  // ************************************************************
  logic [23:0]             pulse_en_r;
  logic [11:0]             thr_sel_r;
  logic [23:0]             edge_en_r;
  logic [11:0]             status_r;
  logic [11:0]             status_nxt;
  logic [11:0]             irq_en_r;
  logic [11:0]             event_hit;
  logic [11:0]             clr_mask;
  logic [31:0]             prdata_r;
  logic                    pready_r;
  logic                    pslverr_r;
  logic                    irq_r;
  logic [NUM_GROUPS*MV_W-1:0] thr_mv_r;
  logic [ADDR_W-3:0]       idx;
  logic                    hit_valid;
  logic [31:0]             rd_word;
  logic                    setup_ph;
  logic                    wr_take;
  logic [31:0]             wdat_pulse;
  logic [31:0]             wdat_thr;
  logic [31:0]             wdat_edge;
  logic [31:0]             wdat_ien;
  logic [31:0]             wdat_clr;

  assign idx      = paddr_i[ADDR_W-1:ADDR_LSB];
  assign setup_ph = psel_i & ~penable_i;
  assign wr_take  = psel_i & penable_i & pready_r & pwrite_i & ~pslverr_r;

  // Read mux; reserved and write-only bits return zero.
  always_comb begin
    hit_valid = 1'b1;
    rd_word   = 32'h0000_0000;
    if (idx == (ADDR_W-2)'(IDX_PULSE_EN)) begin
      rd_word = {8'h00, pulse_en_r};
    end else if (idx == (ADDR_W-2)'(IDX_THR_SEL)) begin
      rd_word = {20'h00000, thr_sel_r};
    end else if (idx == (ADDR_W-2)'(IDX_EDGE_EN_LO)) begin
      rd_word = {8'h00, edge_en_r};
    end else if (idx == (ADDR_W-2)'(IDX_IRQ_STATUS)) begin
      rd_word = {20'h00000, status_r};
    end else if (idx == (ADDR_W-2)'(IDX_IRQ_CLEAR)) begin
      rd_word = 32'h0000_0000;
    end else if (idx == (ADDR_W-2)'(IDX_IRQ_ENABLE)) begin
      rd_word = {20'h00000, irq_en_r};
    end else begin
      hit_valid = 1'b0;
    end
  end

  // Answer is prepared in the setup cycle, so every access has zero wait states.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r  <= 32'h0000_0000;
    end else begin
      pready_r  <= setup_ph;
      pslverr_r <= setup_ph & ~hit_valid;
      prdata_r  <= (setup_ph && !pwrite_i) ? rd_word : 32'h0000_0000;
    end
  end

  // Strobe-merged write values; the slices drop reserved bits.
  assign wdat_pulse = merge_strb({8'h00, pulse_en_r}, pwdata_i, pstrb_i);
  assign wdat_thr   = merge_strb({20'h00000, thr_sel_r}, pwdata_i, pstrb_i);
  assign wdat_edge  = merge_strb({8'h00, edge_en_r}, pwdata_i, pstrb_i);
  assign wdat_ien   = merge_strb({20'h00000, irq_en_r}, pwdata_i, pstrb_i);
  assign wdat_clr   = merge_strb(32'h0000_0000, pwdata_i, pstrb_i);

  // Pulse-current enable, one bit per input.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      pulse_en_r <= PULSE_EN_RST;
    end else if (wr_take && idx == (ADDR_W-2)'(IDX_PULSE_EN)) begin
      pulse_en_r <= wdat_pulse[23:0];
    end
  end

  // Threshold group selects; only bits 11..0 are stored.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      thr_sel_r <= THR_SEL_RST;
    end else if (wr_take && idx == (ADDR_W-2)'(IDX_THR_SEL)) begin
      thr_sel_r <= wdat_thr[11:0];
    end
  end

  // Edge interrupt enables for inputs 0..11.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      edge_en_r <= EDGE_EN_RST;
    end else if (wr_take && idx == (ADDR_W-2)'(IDX_EDGE_EN_LO)) begin
      edge_en_r <= wdat_edge[23:0];
    end
  end

  // Interrupt enable mask.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      irq_en_r <= IRQ_RST;
    end else if (wr_take && idx == (ADDR_W-2)'(IDX_IRQ_ENABLE)) begin
      irq_en_r <= wdat_ien[11:0];
    end
  end

  // ************************************************************
  // Threshold decode
  // ************************************************************
  // Each group's millivolt figure is registered so the output is a flop.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      thr_mv_r <= {NUM_GROUPS{THR_MV_CODE0}};
    end else begin
      for (int g = 0; g < NUM_GROUPS; g++) begin
        thr_mv_r[g*MV_W +: MV_W] <= code_to_mv(thr_sel_r[g*THR_W +: THR_W]);
      end
    end
  end

  // ************************************************************
  // Comparator sampling and edge detection
  // ************************************************************
  // The comparator outputs are asynchronous, so they pass two flops first.
  // Inputs 12 to 23 pass through too but raise nothing here; their enables live elsewhere.
  logic [23:0] comp_meta_r;
  logic [23:0] comp_sync_r;
  logic [23:0] comp_prev_r;
  logic [1:0]  settle_r;
  logic        armed;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      comp_meta_r <= 24'h000000;
      comp_sync_r <= 24'h000000;
      comp_prev_r <= 24'h000000;
    end else begin
      comp_meta_r <= comp_above_i;
      comp_sync_r <= comp_meta_r;
      comp_prev_r <= comp_sync_r;
    end
  end

  // Edges are ignored until the pipeline is full, else a high input at reset
  // release would look like a rising crossing.
  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      settle_r <= 2'd0;
    end else if (settle_r != SETTLE_CYCLES) begin
      settle_r <= settle_r + 2'd1;
    end
  end
  assign armed = (settle_r == SETTLE_CYCLES);

  // Per-input event according to its edge mode.
  for (genvar n = 0; n < EDGE_INPUTS; n++) begin : g_edge
    edge_mode_t mode;
    logic       rise;
    logic       fall;
    assign mode = edge_mode_t'(edge_en_r[n*EDGE_W +: EDGE_W]);
    assign rise = comp_sync_r[n] & ~comp_prev_r[n];
    assign fall = ~comp_sync_r[n] & comp_prev_r[n];
    assign event_hit[n] = edge_event(mode, rise, fall, armed);
  end

  // ************************************************************
  // Interrupt status
  // ************************************************************
  // A new event in the clear cycle survives: set wins over clear.
  assign clr_mask = (wr_take && idx == (ADDR_W-2)'(IDX_IRQ_CLEAR)) ? wdat_clr[11:0] : 12'h000;
  assign status_nxt = (status_r & ~clr_mask) | event_hit;

  always_ff @(posedge clk_i) begin
    if (!nrst_i) begin
      status_r <= IRQ_RST;
      irq_r    <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq_r    <= |(status_r & irq_en_r);
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign prdata_o   = prdata_r;
  assign pready_o   = pready_r;
  assign pslverr_o  = pslverr_r;
  assign pulse_en_o = pulse_en_r;
  assign thr_sel_o  = thr_sel_r;
  assign thr_mv_o   = thr_mv_r;
  assign irq_o      = irq_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  // All checks share the bus clock; a reset aborts any attempt in flight.
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!nrst_i);

  // Helper copy of the last pulse write, compared one edge later.
  logic wr_pulse_q;
  logic [23:0] wr_pulse_d;
  always_ff @(posedge clk_i) begin
    wr_pulse_q <= wr_take && idx == (ADDR_W-2)'(IDX_PULSE_EN);
    wr_pulse_d <= wdat_pulse[23:0];
  end

  a_pulse_write_lands: assert property (wr_pulse_q |-> pulse_en_o == wr_pulse_d)
    else $error("pulse enable write not stored");
  a_thr_mv_map: assert property (##1 thr_mv_o[MV_W-1:0] == code_to_mv($past(thr_sel_r[1:0])))
    else $error("group a millivolt map wrong");
  a_thr_last_group: assert property ($changed(thr_sel_r[11:10]) |=>
      thr_mv_o[5*MV_W +: MV_W] == code_to_mv($past(thr_sel_r[11:10])))
    else $error("group f threshold not following its field");
  a_edge_off_quiet: assert property (edge_en_r[5:4] == 2'b00 |-> !event_hit[2])
    else $error("disabled input raised an event");
  a_rise_event: assert property (armed && edge_en_r[11:10] == 2'b01 && comp_sync_r[5]
      && !comp_prev_r[5] |=> status_r[5])
    else $error("rising crossing not flagged");
  a_fall_event: assert property (armed && edge_en_r[17:16] == 2'b10 && !comp_sync_r[8]
      && comp_prev_r[8] |=> status_r[8])
    else $error("falling crossing not flagged");
  a_both_no_rise_miss: assert property (edge_en_r[23:22] == 2'b11 && armed
      && (comp_sync_r[11] != comp_prev_r[11]) |=> status_r[11])
    else $error("both-edge input missed a crossing");
  a_rise_only_quiet: assert property (edge_en_r[11:10] == 2'b01 && comp_prev_r[5]
      && !comp_sync_r[5] |-> !event_hit[5])
    else $error("rising mode fired on a fall");
  a_reset_zero: assert property ($rose(nrst_i) |-> thr_sel_r == 12'h000
      && edge_en_r == 24'h000000)
    else $error("registers not zero after reset");
  a_thr_rsvd_zero: assert property (pready_o && !pwrite_i && psel_i &&
      idx == (ADDR_W-2)'(IDX_THR_SEL) |-> prdata_o[31:12] == 20'h00000)
    else $error("threshold reserved bits read nonzero");
  a_pulse_reset: assert property ($rose(nrst_i) |-> pulse_en_o == 24'h000000)
    else $error("pulse enables not zero after reset");
  a_set_beats_clear: assert property (event_hit[0] && clr_mask[0] |=> status_r[0])
    else $error("event lost against a clear");
  a_irq_follows: assert property (|(status_r & irq_en_r) |=> irq_o)
    else $error("interrupt not raised for enabled status");
  a_irq_low_idle: assert property (!(|(status_r & irq_en_r)) |=> !irq_o)
    else $error("interrupt high without enabled status");
  a_status_sticky: assert property (status_r[5] && !clr_mask[5] |=> status_r[5])
    else $error("status bit dropped without a clear");

  // Bus handshake and write path checks.
  a_pready_single: assert property (pready_o |=> !pready_o)
    else $error("ready stood longer than one cycle");
  a_slverr_map: assert property (pready_o |-> pslverr_o == !hit_valid)
    else $error("error response does not match decode");
  a_prdata_idle: assert property (!pready_o |-> prdata_o == 32'h0000_0000)
    else $error("read data not zero outside access");
  a_thr_write_slice: assert property (wr_take && idx == (ADDR_W-2)'(IDX_THR_SEL)
      && pstrb_i == 4'hf |=> thr_sel_o == $past(pwdata_i[11:0]))
    else $error("threshold write not stored from low bits");
  a_edge_write_lands: assert property (wr_take && idx == (ADDR_W-2)'(IDX_EDGE_EN_LO)
      && pstrb_i == 4'hf |=> edge_en_r == $past(pwdata_i[23:0]))
    else $error("edge enable write not stored");

  // Covers for the main scenarios.
  c_rise_irq: cover property (edge_en_r[1:0] == 2'b11 ##[1:20] irq_o);
  c_clear_status: cover property (status_r[0] ##1 !status_r[0]);
  c_thr_max: cover property (thr_sel_r[1:0] == 2'b11);
  c_bad_addr: cover property (pslverr_o);
  c_set_vs_clear: cover property (event_hit[0] && clr_mask[0]);

endmodule : sense_cfg_regs
`default_nettype wire

// File: switch_sense_threshold_irq_cfg_test.sv
// Self-checking testbench for the switch-sense configuration register bank.
`timescale 1ns/1ns
`default_nettype none
module switch_sense_threshold_irq_cfg_test;
  import sense_cfg_pkg::*;

  // ************************************************************
  // Design ports and bench bookkeeping.
  // ************************************************************
  logic        clk_i;
  logic        nrst_i;
  logic        psel_i;
  logic        penable_i;
  logic        pwrite_i;
  logic [7:0]  paddr_i;
  logic [31:0] pwdata_i;
  logic [3:0]  pstrb_i;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic [23:0] comp_above_i;
  logic [23:0] pulse_en_o;
  logic [11:0] thr_sel_o;
  logic [71:0] thr_mv_o;
  logic        irq_o;
  int          bad_count;
  int          checked;

  sense_cfg_regs #(.ADDR_W(8)) i_sense_cfg_regs (
    .clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .comp_above_i(comp_above_i), .pulse_en_o(pulse_en_o), .thr_sel_o(thr_sel_o),
    .thr_mv_o(thr_mv_o), .irq_o(irq_o)
  );

  // The clock runs at 10 MHz.
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  // ************************************************************
  // Compare tasks, bus task and closing task.
  // ************************************************************
  task automatic chk_word(input string what, input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic chk_flag(input string what, input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the wait on pready is bounded so a dead slave cannot hang us.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] rd, output logic er);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    pstrb_i   <= s;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 20);
    rd = prdata_o;
    er = pslverr_o;
    if (n >= 20) chk_flag("pready never came", 1'b0, 1'b1);
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, 4'hf, rd, er);
    chk_word(what, rd, exp);
    chk_flag("mapped slverr", er, 1'b0);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, s, rd, er);
  endtask

  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ************************************************************
  // Scenarios.
  // ************************************************************
  task automatic reset_values();
    rd_chk("pulse reset", 8'h80, 32'h0);
    rd_chk("thr reset", 8'h84, 32'h0);
    rd_chk("edge reset", 8'h88, 32'h0);
    rd_chk("status reset", 8'hc0, 32'h0);
    rd_chk("irq enable reset", 8'hc8, 32'h0);
    for (int g = 0; g < 6; g++) chk_word("mv reset", 32'(thr_mv_o[12*g +: 12]), 32'd2000);
  endtask

  // Full write, then a single-lane write must leave the other lanes alone.
  task automatic pulse_enables();
    wr(8'h80, 32'hffffffff, 4'hf);
    rd_chk("pulse readback", 8'h80, 32'h00ffffff);
    chk_word("pulse pins", 32'(pulse_en_o), 32'h00ffffff);
    wr(8'h80, 32'h0, 4'b0001);
    rd_chk("pulse lane", 8'h80, 32'h00ffff00);
    @(posedge clk_i);
    chk_word("pulse pin zero", 32'(pulse_en_o), 32'h00ffff00);
  endtask

  // Each group gets a different code per pass so every code meets every field.
  task automatic thresholds();
    logic [11:0] v;
    logic [11:0] mv [4];
    mv = '{12'd2000, 12'd2700, 12'd3000, 12'd4000};
    wr(8'h84, 32'hffffffff, 4'hf);
    rd_chk("thr reserved", 8'h84, 32'h00000fff);
    for (int k = 0; k < 4; k++) begin
      for (int g = 0; g < 6; g++) v[2*g +: 2] = 2'((g + k) % 4);
      wr(8'h84, {20'hfffff, v}, 4'hf);
      rd_chk("thr value", 8'h84, {20'h0, v});
      repeat (2) @(posedge clk_i);
      chk_word("thr pins", 32'(thr_sel_o), 32'(v));
      for (int g = 0; g < 6; g++) chk_word("mv", 32'(thr_mv_o[12*g +: 12]), 32'(mv[(g + k) % 4]));
    end
  endtask

  // Rise then fall on input n with mode m; input 12 toggles too and must stay silent.
  task automatic edge_case(input int n, input logic [1:0] m);
    wr(8'hc4, 32'hfff, 4'hf);
    wr(8'h88, 32'hff000000 | (32'(m) << (2 * n)), 4'hf);
    rd_chk("edge readback", 8'h88, 32'(m) << (2 * n));
    comp_above_i[n]  <= 1'b1;
    comp_above_i[12] <= 1'b1;
    repeat (8) @(posedge clk_i);
    rd_chk("rise status", 8'hc0, 32'(m[0]) << n);
    wr(8'hc4, 32'hfff, 4'hf);
    comp_above_i[n]  <= 1'b0;
    comp_above_i[12] <= 1'b0;
    repeat (8) @(posedge clk_i);
    rd_chk("fall status", 8'hc0, 32'(m[1]) << n);
  endtask

  task automatic irq_path();
    logic [31:0] rd;
    logic        er;
    edge_case(0, 2'd3);
    wr(8'hc8, 32'h1, 4'hf);
    repeat (2) @(posedge clk_i);
    chk_flag("irq on", irq_o, 1'b1);
    wr(8'hc8, 32'h0, 4'hf);
    repeat (2) @(posedge clk_i);
    chk_flag("irq masked", irq_o, 1'b0);
    wr(8'hc8, 32'h1, 4'hf);
    repeat (2) @(posedge clk_i);
    chk_flag("irq unmasked", irq_o, 1'b1);
    rd_chk("clear reads zero", 8'hc4, 32'h0);
    wr(8'hc4, 32'h1, 4'hf);
    repeat (2) @(posedge clk_i);
    chk_flag("irq cleared", irq_o, 1'b0);
    apb(1'b1, 8'h90, 32'hffffffff, 4'hf, rd, er);
    chk_flag("unmapped write", er, 1'b1);
    apb(1'b0, 8'h90, 32'h0, 4'hf, rd, er);
    chk_flag("unmapped read", er, 1'b1);
    chk_word("unmapped data", rd, 32'h0);
    // Input 0 crosses in the very cycle that its clear lands; the set must survive.
    comp_above_i[0] <= 1'b1;
    wr(8'hc4, 32'h1, 4'hf);
    rd_chk("set beats clear", 8'hc0, 32'h1);
  endtask

  // A reset in mid-run must bring the pulse, threshold, edge and status registers and irq_o back to zero.
  task automatic mid_reset();
    nrst_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    rd_chk("pulse re-reset", 8'h80, 32'h0);
    rd_chk("thr re-reset", 8'h84, 32'h0);
    rd_chk("edge re-reset", 8'h88, 32'h0);
    rd_chk("status re-reset", 8'hc0, 32'h0);
    chk_flag("irq re-reset", irq_o, 1'b0);
  endtask

  // ************************************************************
  // Main sequence and watchdog.
  // ************************************************************
  initial begin
    nrst_i       = 1'b0;
    psel_i       = 1'b0;
    penable_i    = 1'b0;
    pwrite_i     = 1'b0;
    paddr_i      = 8'h0;
    pwdata_i     = 32'h0;
    pstrb_i      = 4'h0;
    comp_above_i = 24'h0;
    bad_count    = 0;
    checked      = 0;
    repeat (12) @(posedge clk_i);
    nrst_i <= 1'b1;
    reset_values();
    pulse_enables();
    thresholds();
    for (int m = 0; m < 4; m++) edge_case(3 * m + 2, 2'(m));
    irq_path();
    mid_reset();
    end_sim();
  end

  // Whole run needs well under 2000 cycles; 20000 means something hung.
  initial begin
    #2000000;
    bad_count++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_sim();
  end

endmodule // switch_sense_threshold_irq_cfg_test
`default_nettype wire
